/* ucs_pkg.sv */
package ucs_pkg;
    // register byte addresses
    localparam logic [7:0] OFF_CTRL    = 8'hB8;
    localparam logic [7:0] OFF_LOC     = 8'hBC;
    localparam logic [7:0] OFF_DATA    = 8'hC0;
    localparam logic [7:0] OFF_STATUS  = 8'hC4;
    localparam logic [7:0] OFF_PINCFG  = 8'hC8;

    // control register fields
    localparam int CTRL_SRC_HI     = 3;
    localparam int CTRL_SRC_LO     = 2;
    localparam int CTRL_STROBE_BIT = 1;
    localparam int CTRL_TOGGLE_BIT = 0;

    // pin configuration fields
    localparam int PINCFG_CLK_DIR  = 0;
    localparam int PINCFG_DO_DIR   = 1;

    localparam int LOC_SEL_BIT     = 0;
    localparam int DATA_MSB        = 7;
    localparam int CNT_W           = 4;
    localparam int DATA_W          = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [3:0] CNT_RST   = 4'h0;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic       PORT_B    = 1'b0;
    localparam logic       PORT_A    = 1'b1;

    typedef enum logic [1:0] {
        SRC_NONE    = 2'b00,
        SRC_TIMER   = 2'b01,
        SRC_EXT_POS = 2'b10,
        SRC_EXT_NEG = 2'b11
    } ucs_src_t;
endpackage : ucs_pkg

/* ucs_sync2.sv */
`timescale 1ns/10ps
module ucs_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule : ucs_sync2

/* ucs_link_capture.sv */
`timescale 1ns/10ps
// runs on the serial clock line itself; each edge flips a toggle and
// catches both data-in pin positions so the system side can pick one
module ucs_link_capture (
    input  wire logic       link_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [1:0] di_pins_i,
    output logic            pos_tgl_o,
    output logic            neg_tgl_o,
    output logic [1:0]      pos_bits_o,
    output logic [1:0]      neg_bits_o
);
    logic       pos_tgl_ff;
    logic       neg_tgl_ff;
    logic [1:0] pos_bits_ff;
    logic [1:0] neg_bits_ff;
    logic       nxt_pos_tgl;
    logic       nxt_neg_tgl;

    always_comb begin
        nxt_pos_tgl = ~pos_tgl_ff;
        nxt_neg_tgl = ~neg_tgl_ff;
    end

    always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pos_tgl_ff  <= 1'b0;
            pos_bits_ff <= 2'h0;
        end else begin
            pos_tgl_ff  <= nxt_pos_tgl;
            pos_bits_ff <= di_pins_i;
        end
    end

    always_ff @(negedge link_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            neg_tgl_ff  <= 1'b0;
            neg_bits_ff <= 2'h0;
        end else begin
            neg_tgl_ff  <= nxt_neg_tgl;
            neg_bits_ff <= di_pins_i;
        end
    end

    assign pos_tgl_o  = pos_tgl_ff;
    assign neg_tgl_o  = neg_tgl_ff;
    assign pos_bits_o = pos_bits_ff;
    assign neg_bits_o = neg_bits_ff;
endmodule : ucs_link_capture

/* ucs_clock_select.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
// Contract
// - one two-bit source select picks the clocks for both the shift register and the 4-bit counter.
// - select 00 gives no clock, 01 clocks both from the timer match, 10/11 shift on rising/falling edge and count both.
// - under external clocking the data output moves on the edge opposite to the sampling edge.
// - under strobe or timer clocking the output latch is transparent.
// - with select 00 a one written to the strobe bit shifts once and counts once; the bit reads as zero.
// - a strobe changes the data output in the same cycle as its write.
// - a strobe shifts in the input value captured the cycle before the write.
// - with an external source the strobe bit is a stored selector for the counter clock.
// - with external source and the selector set, each toggle write clocks the counter.
// - a one written to the toggle bit inverts the clock pin output value; the bit reads as zero.
// - the toggle happens whatever the direction, but shows on the pin only when the direction bit is output.
// - the location bit routes data in, data out and clock to port B when 0 and port A when 1.
// - location register bits 7:1 read zero, bit 0 is read/write and resets to zero.
module ucs_clock_select (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        link_clk_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        timer_match_i,
    input  wire logic        pb_di_i,
    input  wire logic        pa_di_i,
    output logic             pb_do_o,
    output logic             pb_do_oe_o,
    output logic             pa_do_o,
    output logic             pa_do_oe_o,
    output logic             pb_clk_o,
    output logic             pb_clk_oe_o,
    output logic             pa_clk_o,
    output logic             pa_clk_oe_o
);
    logic [7:0]        dph_addr_ff;
    logic              dph_wr_ff;
    logic [31:0]       hrdata_ff;
    logic [7:0]        nxt_dph_addr;
    logic              nxt_dph_wr;
    logic [31:0]       nxt_hrdata;

    ucs_pkg::ucs_src_t src_ff;
    ucs_pkg::ucs_src_t nxt_src;
    logic              stb_sel_ff;
    logic              loc_ff;
    logic              clk_dir_ff;
    logic              do_dir_ff;
    logic [7:0]        data_ff;
    logic [3:0]        cnt_ff;
    logic              do_ff;
    logic              clk_pin_ff;
    logic              di_prev_ff;
    logic              nxt_stb_sel;
    logic              nxt_loc;
    logic              nxt_clk_dir;
    logic              nxt_do_dir;
    logic [7:0]        nxt_data;
    logic [3:0]        nxt_cnt;
    logic              nxt_do;
    logic              nxt_clk_pin;
    logic              nxt_di_prev;

    logic              pb_do_ff;
    logic              pb_do_oe_ff;
    logic              pa_do_ff;
    logic              pa_do_oe_ff;
    logic              pb_clk_ff;
    logic              pb_clk_oe_ff;
    logic              pa_clk_ff;
    logic              pa_clk_oe_ff;

    logic              pos_tgl;
    logic              neg_tgl;
    logic [1:0]        pos_bits;
    logic [1:0]        neg_bits;
    logic [1:0]        tgl_sync;
    logic [1:0]        di_sync;
    logic [1:0]        tgl_prev_ff;
    logic              pos_evt;
    logic              neg_evt;

    logic              addr_ok;
    logic              wr_ctrl;
    logic              wr_loc;
    logic              wr_data;
    logic              wr_status;
    logic              wr_pincfg;
    logic              soft_evt;
    logic              toggle_evt;
    logic              shift_evt;
    logic              shift_in;
    logic [1:0]        cnt_add;
    logic              di_now;

    function automatic logic [31:0] read_mux(input logic [7:0] a, input ucs_pkg::ucs_src_t s,
                                             input logic l, input logic [7:0] d, input logic [3:0] c,
                                             input logic cd, input logic dd);
        logic [31:0] r;
        r = '0;
        case (a)
            ucs_pkg::OFF_CTRL:   r[ucs_pkg::CTRL_SRC_HI:ucs_pkg::CTRL_SRC_LO] = s;
            ucs_pkg::OFF_LOC:    r[ucs_pkg::LOC_SEL_BIT] = l;
            ucs_pkg::OFF_DATA:   r[ucs_pkg::DATA_W-1:0] = d;
            ucs_pkg::OFF_STATUS: r[ucs_pkg::CNT_W-1:0] = c;
            ucs_pkg::OFF_PINCFG: begin
                r[ucs_pkg::PINCFG_CLK_DIR] = cd;
                r[ucs_pkg::PINCFG_DO_DIR]  = dd;
            end
            default:             r = '0;
        endcase
        return r;
    endfunction : read_mux

    ucs_link_capture u_link (
        .link_clk_i (link_clk_i),
        .sys_rst_i  (sys_rst_i),
        .di_pins_i  ({pa_di_i, pb_di_i}),
        .pos_tgl_o  (pos_tgl),
        .neg_tgl_o  (neg_tgl),
        .pos_bits_o (pos_bits),
        .neg_bits_o (neg_bits)
    );

    ucs_sync2 #(.W(2)) u_tgl_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({neg_tgl, pos_tgl}),
        .sync_o    (tgl_sync)
    );

    ucs_sync2 #(.W(2)) u_di_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({pa_di_i, pb_di_i}),
        .sync_o    (di_sync)
    );

    // link edges arrive as toggles; the caught bits stand until the next
    // edge of that polarity, so edges must be a few system cycles apart
    assign pos_evt = tgl_sync[0] ^ tgl_prev_ff[0];
    assign neg_evt = tgl_sync[1] ^ tgl_prev_ff[1];
    assign di_now  = di_sync[loc_ff];

    // bus decode: zero wait states, so hready is always high
    always_comb begin
        addr_ok      = hsel_i && hready_i && (htrans_i == ucs_pkg::HTRANS_NONSEQ);
        nxt_dph_addr = addr_ok ? haddr_i[7:0] : dph_addr_ff;
        nxt_dph_wr   = addr_ok && hwrite_i;
        nxt_hrdata   = hrdata_ff;
        if (addr_ok && !hwrite_i) begin
            nxt_hrdata = read_mux(haddr_i[7:0], src_ff, loc_ff, data_ff, cnt_ff, clk_dir_ff, do_dir_ff);
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dph_addr_ff <= ucs_pkg::BYTE_ZERO;
            dph_wr_ff   <= 1'b0;
            hrdata_ff   <= '0;
        end else begin
            dph_addr_ff <= nxt_dph_addr;
            dph_wr_ff   <= nxt_dph_wr;
            hrdata_ff   <= nxt_hrdata;
        end
    end

    always_comb begin
        wr_ctrl    = dph_wr_ff && (dph_addr_ff == ucs_pkg::OFF_CTRL);
        wr_loc     = dph_wr_ff && (dph_addr_ff == ucs_pkg::OFF_LOC);
        wr_data    = dph_wr_ff && (dph_addr_ff == ucs_pkg::OFF_DATA);
        wr_status  = dph_wr_ff && (dph_addr_ff == ucs_pkg::OFF_STATUS);
        wr_pincfg  = dph_wr_ff && (dph_addr_ff == ucs_pkg::OFF_PINCFG);
        soft_evt   = wr_ctrl && hwdata_i[ucs_pkg::CTRL_STROBE_BIT] && (src_ff == ucs_pkg::SRC_NONE);
        toggle_evt = wr_ctrl && hwdata_i[ucs_pkg::CTRL_TOGGLE_BIT];
        shift_evt  = 1'b0;
        shift_in   = 1'b0;
        cnt_add    = 2'h0;
        // the source select picks the clocks for both the shift register and the counter
        case (src_ff)
            ucs_pkg::SRC_NONE: begin
                shift_evt = soft_evt;
                shift_in  = di_prev_ff;
                cnt_add   = {1'b0, soft_evt};
            end
            ucs_pkg::SRC_TIMER: begin
                shift_evt = timer_match_i;
                shift_in  = di_now;
                cnt_add   = {1'b0, timer_match_i};
            end
            ucs_pkg::SRC_EXT_POS: begin
                shift_evt = pos_evt;
                shift_in  = pos_bits[loc_ff];
                cnt_add   = stb_sel_ff ? {1'b0, toggle_evt} : ({1'b0, pos_evt} + {1'b0, neg_evt});
            end
            ucs_pkg::SRC_EXT_NEG: begin
                shift_evt = neg_evt;
                shift_in  = neg_bits[loc_ff];
                cnt_add   = stb_sel_ff ? {1'b0, toggle_evt} : ({1'b0, pos_evt} + {1'b0, neg_evt});
            end
            default: begin
                shift_evt = 1'b0;
                shift_in  = 1'b0;
                cnt_add   = 2'h0;
            end
        endcase
    end

    always_comb begin
        nxt_src     = src_ff;
        nxt_stb_sel = stb_sel_ff;
        nxt_loc     = loc_ff;
        nxt_clk_dir = clk_dir_ff;
        nxt_do_dir  = do_dir_ff;
        nxt_data    = data_ff;
        nxt_cnt     = cnt_ff;
        nxt_do      = do_ff;
        nxt_clk_pin = clk_pin_ff;
        nxt_di_prev = di_now;
        if (wr_ctrl) begin
            nxt_src     = ucs_pkg::ucs_src_t'(hwdata_i[ucs_pkg::CTRL_SRC_HI:ucs_pkg::CTRL_SRC_LO]);
            nxt_stb_sel = hwdata_i[ucs_pkg::CTRL_STROBE_BIT];
        end
        if (wr_loc) begin
            nxt_loc = hwdata_i[ucs_pkg::LOC_SEL_BIT];
        end
        if (wr_pincfg) begin
            nxt_clk_dir = hwdata_i[ucs_pkg::PINCFG_CLK_DIR];
            nxt_do_dir  = hwdata_i[ucs_pkg::PINCFG_DO_DIR];
        end
        // a software load of the data or count overrides a clock in the same cycle
        if (wr_data) begin
            nxt_data = hwdata_i[ucs_pkg::DATA_W-1:0];
        end else if (shift_evt) begin
            nxt_data = {data_ff[ucs_pkg::DATA_MSB-1:0], shift_in};
        end
        if (wr_status) begin
            nxt_cnt = hwdata_i[ucs_pkg::CNT_W-1:0];
        end else begin
            nxt_cnt = cnt_ff + {2'h0, cnt_add};
        end
        if (toggle_evt) begin
            nxt_clk_pin = ~clk_pin_ff;
        end
        case (src_ff)
            ucs_pkg::SRC_EXT_POS: begin
                if (neg_evt) begin
                    nxt_do = data_ff[ucs_pkg::DATA_MSB];
                end
            end
            ucs_pkg::SRC_EXT_NEG: begin
                if (pos_evt) begin
                    nxt_do = data_ff[ucs_pkg::DATA_MSB];
                end
            end
            default: nxt_do = nxt_data[ucs_pkg::DATA_MSB];
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src_ff       <= ucs_pkg::SRC_NONE;
            stb_sel_ff   <= 1'b0;
            loc_ff       <= ucs_pkg::PORT_B;
            clk_dir_ff   <= 1'b0;
            do_dir_ff    <= 1'b0;
            data_ff      <= ucs_pkg::DATA_RST;
            cnt_ff       <= ucs_pkg::CNT_RST;
            do_ff        <= 1'b0;
            clk_pin_ff   <= 1'b0;
            di_prev_ff   <= 1'b0;
            tgl_prev_ff  <= 2'h0;
            pb_do_ff     <= 1'b0;
            pb_do_oe_ff  <= 1'b0;
            pa_do_ff     <= 1'b0;
            pa_do_oe_ff  <= 1'b0;
            pb_clk_ff    <= 1'b0;
            pb_clk_oe_ff <= 1'b0;
            pa_clk_ff    <= 1'b0;
            pa_clk_oe_ff <= 1'b0;
        end else begin
            src_ff       <= nxt_src;
            stb_sel_ff   <= nxt_stb_sel;
            loc_ff       <= nxt_loc;
            clk_dir_ff   <= nxt_clk_dir;
            do_dir_ff    <= nxt_do_dir;
            data_ff      <= nxt_data;
            cnt_ff       <= nxt_cnt;
            do_ff        <= nxt_do;
            clk_pin_ff   <= nxt_clk_pin;
            di_prev_ff   <= nxt_di_prev;
            tgl_prev_ff  <= tgl_sync;
            // pins follow the new values in the same edge so a strobe shows at once
            pb_do_ff     <= nxt_do;
            pa_do_ff     <= nxt_do;
            pb_clk_ff    <= nxt_clk_pin;
            pa_clk_ff    <= nxt_clk_pin;
            pb_do_oe_ff  <= nxt_do_dir && (nxt_loc == ucs_pkg::PORT_B);
            pa_do_oe_ff  <= nxt_do_dir && (nxt_loc == ucs_pkg::PORT_A);
            pb_clk_oe_ff <= nxt_clk_dir && (nxt_loc == ucs_pkg::PORT_B);
            pa_clk_oe_ff <= nxt_clk_dir && (nxt_loc == ucs_pkg::PORT_A);
        end
    end

    assign hrdata_o    = hrdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign pb_do_o     = pb_do_ff;
    assign pb_do_oe_o  = pb_do_oe_ff;
    assign pa_do_o     = pa_do_ff;
    assign pa_do_oe_o  = pa_do_oe_ff;
    assign pb_clk_o    = pb_clk_ff;
    assign pb_clk_oe_o = pb_clk_oe_ff;
    assign pa_clk_o    = pa_clk_ff;
    assign pa_clk_oe_o = pa_clk_oe_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_src_none_idle: assert property (
        (src_ff == ucs_pkg::SRC_NONE) && !soft_evt && !wr_status && !wr_data
        |=> $stable(cnt_ff) && $stable(data_ff))
        else $error("counter or data moved with no clock");
    a_timer_count: assert property (
        (src_ff == ucs_pkg::SRC_TIMER) && timer_match_i && !wr_status
        |=> cnt_ff == $past(cnt_ff) + 4'h1)
        else $error("timer match did not count");
    a_strobe_shift: assert property (
        soft_evt && !wr_data
        |=> data_ff == {$past(data_ff[6:0]), $past(di_prev_ff)})
        else $error("strobe shifted wrong bit");
    a_strobe_out_now: assert property (
        soft_evt && !wr_data |=> do_ff == $past(data_ff[6]) && pb_do_ff == do_ff)
        else $error("strobe output not immediate");
    a_toggle_pin: assert property (
        toggle_evt |=> clk_pin_ff != $past(clk_pin_ff))
        else $error("toggle did not invert clock pin");
    a_toggle_counts: assert property (
        src_ff[1] && stb_sel_ff && toggle_evt && !wr_status |=> cnt_ff == $past(cnt_ff) + 4'h1)
        else $error("toggle did not clock counter");
    a_ext_edge_cnt: assert property (
        src_ff[1] && !stb_sel_ff && (pos_evt != neg_evt) && !wr_status
        |=> cnt_ff == $past(cnt_ff) + 4'h1)
        else $error("external edge not counted");
    a_opposite_edge: assert property (
        (src_ff == ucs_pkg::SRC_EXT_POS) && !neg_evt |=> $stable(do_ff))
        else $error("output moved off the opposite edge");
    a_loc_route: assert property (
        (loc_ff == ucs_pkg::PORT_B) && !wr_loc |=> !pa_do_oe_o && !pa_clk_oe_o)
        else $error("port A driven while port B selected");
    a_dir_gate: assert property (
        !clk_dir_ff && !wr_pincfg |=> !pb_clk_oe_o && !pa_clk_oe_o)
        else $error("clock pin driven while direction is input");
    a_ctrl_reads: assert property (
        addr_ok && !hwrite_i && (haddr_i[7:0] == ucs_pkg::OFF_CTRL) |=> hrdata_o[1:0] == 2'h0)
        else $error("strobe bits read non-zero");

    c_soft_strobe: cover property (soft_evt ##[1:20] soft_evt);
    c_ext_wrap:    cover property (src_ff[1] && (cnt_ff == 4'hF) ##1 (cnt_ff == 4'h0));
    c_toggle_cnt:  cover property (src_ff[1] && stb_sel_ff && toggle_evt);
    c_port_a:      cover property (loc_ff && pa_clk_oe_o);
endmodule : ucs_clock_select

/* ucs_serial_peer.sv */
`timescale 1ns/10ps
// far-side serial master; its clock stands low between frames
module ucs_serial_peer (
    input  wire logic       osc_i,
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic [2:0] nclk_i,
    input  wire logic [7:0] tx_i,
    output logic            sclk_o,
    output logic            di_o,
    output logic            busy_o
);
    int h;
    initial begin
        sclk_o = 1'b0;
        di_o   = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge osc_i);
            if (go_i) begin
                busy_o = 1'b1;
                h = slow_i ? 40 : 20;
                for (int i = 0; i < int'(nclk_i); i++) begin
                    // set mid-low so the bit is steady across both edges
                    di_o = tx_i[7-i];
                    repeat (h) @(posedge osc_i);
                    sclk_o = 1'b1;
                    repeat (h) @(posedge osc_i);
                    sclk_o = 1'b0;
                    repeat (h) @(posedge osc_i);
                end
                busy_o = 1'b0;
            end else begin
                // released line with no pull: never a steady value
                di_o = ~di_o;
            end
        end
    end
endmodule : ucs_serial_peer

/* ucs_clock_select_tb.sv */
`timescale 1ns/10ps
module ucs_clock_select_tb;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        osc = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0, hready, timer = 1'b0, tb_di = 1'b0, ext = 1'b0, loc = 1'b0, hresp;
    logic        go = 1'b0, slow = 1'b0, sclk, pdi, busy, src;
    logic        pb_do, pb_do_oe, pa_do, pa_do_oe, pb_clk, pb_clk_oe, pa_clk, pa_clk_oe;
    logic [2:0]  nclk = 3'h1;
    logic [7:0]  tx = 8'h00, d, t, p;
    logic [3:0]  c;
    int          n_fail = 0, cmp_count = 0, seed = 25508, n;

    initial forever #50 clk_i = ~clk_i;
    initial begin
        #3;
        forever #6 osc = ~osc;
    end
    assign src = ext ? pdi : tb_di;

    ucs_clock_select uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(sclk), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .timer_match_i(timer), .pb_di_i(loc ? ~src : src),
        .pa_di_i(loc ? src : ~src), .pb_do_o(pb_do), .pb_do_oe_o(pb_do_oe), .pa_do_o(pa_do), .pa_do_oe_o(pa_do_oe),
        .pb_clk_o(pb_clk), .pb_clk_oe_o(pb_clk_oe), .pa_clk_o(pa_clk), .pa_clk_oe_o(pa_clk_oe));
    ucs_serial_peer peer (.osc_i(osc), .go_i(go), .slow_i(slow), .nclk_i(nclk), .tx_i(tx), .sclk_o(sclk),
        .di_o(pdi), .busy_o(busy));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= ucs_pkg::HTRANS_NONSEQ;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        r = hrdata;
        #1;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, r, e);
        chk("hresp", hresp, 0);
    endtask : rdchk

    function automatic logic [7:0] shifted(input logic [7:0] dv, input logic [7:0] tv, input int nb);
        logic [15:0] w;
        w = {dv, tv};
        return w[15-nb -: 8];
    endfunction : shifted

    task automatic frame(input logic [2:0] nb, input logic [7:0] tv, input logic sl);
        int k;
        tx   <= tv;
        nclk <= nb;
        slow <= sl;
        ext  <= 1'b1;
        go   <= 1'b1;
        k = 0;
        while (busy !== 1'b1 && k < 50) begin
            @(posedge clk_i);
            k++;
        end
        go <= 1'b0;
        // a peer that never starts or never ends counts as a mismatch
        if (k >= 50)
            n_fail++;
        k = 0;
        while (busy !== 1'b0 && k < 300) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 300)
            n_fail++;
        repeat (5) @(posedge clk_i);
        ext <= 1'b0;
        #1;
    endtask : frame

    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rdchk(ucs_pkg::OFF_LOC, 0, "loc_reset");
        bus(1'b1, ucs_pkg::OFF_LOC, 32'hFFFFFFFF);
        rdchk(ucs_pkg::OFF_LOC, 1, "loc_bits");
        rdchk(8'hF0, 0, "unmapped");
        bus(1'b1, ucs_pkg::OFF_LOC, 0);
        bus(1'b1, ucs_pkg::OFF_PINCFG, 3);
        d = 8'($random(seed));
        c = 4'h0;
        bus(1'b1, ucs_pkg::OFF_DATA, d);
        bus(1'b1, ucs_pkg::OFF_STATUS, 0);
        // 17 strobes so the counter wraps once
        for (int i = 0; i < 17; i++) begin
            tb_di <= 1'($random(seed));
            repeat (4) @(posedge clk_i);
            bus(1'b1, ucs_pkg::OFF_CTRL, 32'h2);
            d = shifted(d, {tb_di, 7'h0}, 1);
            c++;
            chk("strobe_do", pb_do, d[7]);
            rdchk(ucs_pkg::OFF_CTRL, 0, "ctrl_read");
            rdchk(ucs_pkg::OFF_DATA, d, "strobe_data");
            rdchk(ucs_pkg::OFF_STATUS, c, "strobe_count");
        end
        bus(1'b1, ucs_pkg::OFF_CTRL, 0);
        rdchk(ucs_pkg::OFF_DATA, d, "no_clock");
        bus(1'b1, ucs_pkg::OFF_CTRL, 32'h4);
        n = 1 + ($random(seed) & 3);
        for (int i = 0; i < n; i++) begin
            timer <= 1'b1;
            @(posedge clk_i);
            timer <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        #1;
        d = shifted(d, {8{tb_di}}, n);
        c = c + 4'(n);
        chk("timer_do", pb_do, d[7]);
        rdchk(ucs_pkg::OFF_DATA, d, "timer_data");
        rdchk(ucs_pkg::OFF_STATUS, c, "timer_count");
        bus(1'b1, ucs_pkg::OFF_CTRL, 0);
        bus(1'b1, ucs_pkg::OFF_PINCFG, 2);
        bus(1'b1, ucs_pkg::OFF_CTRL, 1);
        chk("clk_oe_off", pb_clk_oe, 0);
        bus(1'b1, ucs_pkg::OFF_PINCFG, 3);
        chk("clk_toggled", {pb_clk_oe, pb_clk}, 2'b11);
        bus(1'b1, ucs_pkg::OFF_CTRL, 1);
        chk("clk_back", {pa_clk, pb_clk}, 0);
        rdchk(ucs_pkg::OFF_CTRL, 0, "toggle_read");
        for (int j = 0; j < 4; j++) begin
            loc <= j[0];
            bus(1'b1, ucs_pkg::OFF_LOC, j & 1);
            chk("loc_oe", {pa_clk_oe, pb_clk_oe, pa_do_oe, pb_do_oe}, j[0] ? 4'hA : 4'h5);
            bus(1'b1, ucs_pkg::OFF_CTRL, (2 + j / 2) << 2);
            d = 8'($random(seed));
            t = 8'($random(seed));
            n = 1 + ($random(seed) & 7) % 7;
            c = 4'($random(seed));
            bus(1'b1, ucs_pkg::OFF_DATA, d);
            bus(1'b1, ucs_pkg::OFF_STATUS, c);
            frame(3'(n), t, j[0]);
            // falling-edge shifting leaves the output one shift behind
            p = shifted(d, t, n - j / 2);
            d = shifted(d, t, n);
            rdchk(ucs_pkg::OFF_DATA, d, "ext_data");
            rdchk(ucs_pkg::OFF_STATUS, 4'(c + 2 * n), "ext_count");
            chk("ext_do", j[0] ? pa_do : pb_do, p[7]);
        end
        loc <= 1'b0;
        bus(1'b1, ucs_pkg::OFF_LOC, 0);
        bus(1'b1, ucs_pkg::OFF_CTRL, 32'hA);
        bus(1'b1, ucs_pkg::OFF_STATUS, 0);
        for (int i = 0; i < 3; i++)
            bus(1'b1, ucs_pkg::OFF_CTRL, 32'hB);
        rdchk(ucs_pkg::OFF_STATUS, 3, "tgl_count");
        frame(3'h2, 8'hC3, 1'b0);
        rdchk(ucs_pkg::OFF_STATUS, 3, "ext_ignored");
        // second reset in mid-run with port A selected and pins enabled
        bus(1'b1, ucs_pkg::OFF_LOC, 1);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk("pins_rerun", {pa_clk_oe, pb_clk_oe, pa_do_oe, pb_do_oe}, 0);
        rdchk(ucs_pkg::OFF_LOC, 0, "loc_rerun");
        rdchk(ucs_pkg::OFF_STATUS, 0, "cnt_rerun");
        end_sim;
    end

    initial begin
        #2_000_000;
        n_fail++;
        end_sim;
    end
endmodule : ucs_clock_select_tb
